// ==== verilog/lrt_map.svh ====
// Register offsets, field positions and reset values of the receive tuning register.
`ifndef LRT_MAP_SVH
`define LRT_MAP_SVH
`define LRT_ADDR_W 7
`define LRT_TUNE_ADDR 7'h42
`define LRT_TUNE_RESET 8'h00
`define LRT_GAUGE_HI 7
`define LRT_GAUGE_LO 6
`define LRT_TXON_BIT 5
`define LRT_TERM_BIT 4
`define LRT_SLICE_HI 3
`define LRT_SLICE_LO 2
`define LRT_EQ_HI 1
`define LRT_EQ_LO 0
`define LRT_FIELD_W 2
`define LRT_FOLD_CODE 2'h3
`define LRT_FOLD_TARGET 2'h0
`define LRT_UNMAPPED_RDATA 8'h00
`endif

// ==== verilog/lrt_pkg.sv ====
// Types for the receive tuning register block.
`default_nettype none
package lrt_pkg;
  typedef enum logic [1:0] {LRT_WIRE_MIXED, LRT_WIRE_22, LRT_WIRE_24, LRT_WIRE_26} lrt_wire_t;
  typedef enum logic [1:0] {LRT_SLICE_NOMINAL, LRT_SLICE_DOWN5, LRT_SLICE_UP5} lrt_slice_t;
  typedef enum logic [1:0] {LRT_EQ_NOMINAL, LRT_EQ_CUT1DB, LRT_EQ_CUT3DB} lrt_eq_t;
  typedef struct packed {
    lrt_wire_t wire_gauge;
    lrt_slice_t slicer_level;
    lrt_eq_t eq_gain;
    logic tx_enable_pin_handover;
    logic termination_pin_handover;
  } lrt_tuning_t;
endpackage
`default_nettype wire

// ==== verilog/lrt_tuning_reg.sv ====
// Receive tuning control register with decoded analog settings.
// Functional notes
// - Gauge bits 7:6 select cable wire size.
// - Slicer bits 3:2: nominal, minus5, plus5, nominal.
// - Equalizer bits 1:0: nominal, -1dB, -3dB, nominal.
// - All bits read/write, reset to zero.
`include "lrt_map.svh"
`default_nettype none
module lrt_code_fold #(
  parameter int CODE_W = `LRT_FIELD_W,
  parameter logic [CODE_W-1:0] FOLD_FROM = `LRT_FOLD_CODE,
  parameter logic [CODE_W-1:0] FOLD_TO = `LRT_FOLD_TARGET
) (
  input wire logic [CODE_W-1:0] code_in,
  output logic [CODE_W-1:0] code_out
);
  // A duplicate code is mapped onto its twin, so the settings downstream have one encoding each.
  always_comb begin
    if (code_in == FOLD_FROM) begin
      code_out = FOLD_TO;
    end else begin
      code_out = code_in;
    end
  end
endmodule // lrt_code_fold

module lrt_tuning_reg #(
  parameter int ADDR_W = `LRT_ADDR_W
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic host_wr,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output var lrt_pkg::lrt_tuning_t tuning
);
  localparam logic [ADDR_W-1:0] TUNE_ADDR = ADDR_W'(`LRT_TUNE_ADDR);
  localparam logic [7:0] TUNE_RESET_BYTE = `LRT_TUNE_RESET;
  localparam logic [7:0] UNMAPPED_BYTE = `LRT_UNMAPPED_RDATA;
  localparam logic [`LRT_FIELD_W-1:0] FOLD_CODE = `LRT_FOLD_CODE;
  localparam logic [`LRT_FIELD_W-1:0] FOLD_TARGET = `LRT_FOLD_TARGET;

  logic sel;
  logic wr_hit;
  logic [7:0] tune_reg;
  logic [7:0] tune_next;
  logic [7:0] host_rdata_reg;
  logic [7:0] host_rdata_next;
  logic [`LRT_FIELD_W-1:0] gauge_raw;
  logic [`LRT_FIELD_W-1:0] slicer_raw;
  logic [`LRT_FIELD_W-1:0] eq_raw;
  logic [`LRT_FIELD_W-1:0] slicer_folded;
  logic [`LRT_FIELD_W-1:0] eq_folded;
  lrt_pkg::lrt_wire_t wire_gauge_reg;
  lrt_pkg::lrt_slice_t slicer_level_reg;
  lrt_pkg::lrt_eq_t eq_gain_reg;
  logic tx_handover_reg;
  logic term_handover_reg;

  // Only one register lives here, so every other address is simply not selected.
  always_comb begin
    if (host_addr == TUNE_ADDR) begin
      sel = 1'b1;
    end else begin
      sel = 1'b0;
    end
  end

  assign wr_hit = host_wr && sel;

  // Whole byte taken at once so the analog side never sees a half-updated setting.
  always_comb begin
    if (wr_hit) begin
      tune_next = host_wdata;
    end else begin
      tune_next = tune_reg;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tune_reg <= TUNE_RESET_BYTE;
    end else begin
      tune_reg <= tune_next;
    end
  end

  // A read in the write cycle returns the new byte; unmapped addresses read as zero.
  always_comb begin
    if (wr_hit) begin
      host_rdata_next = host_wdata;
    end else if (sel) begin
      host_rdata_next = tune_reg;
    end else begin
      host_rdata_next = UNMAPPED_BYTE;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_rdata_reg <= TUNE_RESET_BYTE;
    end else begin
      host_rdata_reg <= host_rdata_next;
    end
  end

  assign host_rdata = host_rdata_reg;

  assign gauge_raw = tune_reg[`LRT_GAUGE_HI:`LRT_GAUGE_LO];
  assign slicer_raw = tune_reg[`LRT_SLICE_HI:`LRT_SLICE_LO];
  assign eq_raw = tune_reg[`LRT_EQ_HI:`LRT_EQ_LO];

  lrt_code_fold #(
    .CODE_W(`LRT_FIELD_W),
    .FOLD_FROM(FOLD_CODE),
    .FOLD_TO(FOLD_TARGET)
  ) u_slicer_fold (
    .code_in(slicer_raw),
    .code_out(slicer_folded)
  );

  lrt_code_fold #(
    .CODE_W(`LRT_FIELD_W),
    .FOLD_FROM(FOLD_CODE),
    .FOLD_TO(FOLD_TARGET)
  ) u_eq_fold (
    .code_in(eq_raw),
    .code_out(eq_folded)
  );

  // The decoded settings lag the register by one cycle, which keeps the analog controls glitch free.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wire_gauge_reg <= lrt_pkg::lrt_wire_t'(TUNE_RESET_BYTE[`LRT_GAUGE_HI:`LRT_GAUGE_LO]);
    end else begin
      wire_gauge_reg <= lrt_pkg::lrt_wire_t'(gauge_raw);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      slicer_level_reg <= lrt_pkg::lrt_slice_t'(TUNE_RESET_BYTE[`LRT_SLICE_HI:`LRT_SLICE_LO]);
    end else begin
      slicer_level_reg <= lrt_pkg::lrt_slice_t'(slicer_folded);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      eq_gain_reg <= lrt_pkg::lrt_eq_t'(TUNE_RESET_BYTE[`LRT_EQ_HI:`LRT_EQ_LO]);
    end else begin
      eq_gain_reg <= lrt_pkg::lrt_eq_t'(eq_folded);
    end
  end

  // The two pin handover bits pass through undecoded; the pin logic that uses them lives elsewhere.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_handover_reg <= TUNE_RESET_BYTE[`LRT_TXON_BIT];
    end else begin
      tx_handover_reg <= tune_reg[`LRT_TXON_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      term_handover_reg <= TUNE_RESET_BYTE[`LRT_TERM_BIT];
    end else begin
      term_handover_reg <= tune_reg[`LRT_TERM_BIT];
    end
  end

  assign tuning = '{
    wire_gauge: wire_gauge_reg,
    slicer_level: slicer_level_reg,
    eq_gain: eq_gain_reg,
    tx_enable_pin_handover: tx_handover_reg,
    termination_pin_handover: term_handover_reg
  };

  a_write_reads_back: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_hit |=> host_rdata == $past(host_wdata))
    else $error("write not reflected on read");

  a_read_returns_reg: assert property (@(posedge core_clk) disable iff (!reset_n)
    sel && !host_wr |=> host_rdata == $past(tune_reg))
    else $error("read does not return the stored byte");

  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    !sel |=> host_rdata == UNMAPPED_BYTE)
    else $error("unmapped address did not read as zero");

  a_reset_zero: assert property (@(posedge core_clk)
    $rose(reset_n) |-> tune_reg == TUNE_RESET_BYTE && host_rdata == TUNE_RESET_BYTE)
    else $error("register not zero after reset");

  a_hold_no_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    !wr_hit |=> $stable(tune_reg))
    else $error("register changed without write");

  a_gauge_decode: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_hit ##1 !host_wr |=> tuning.wire_gauge == $past(host_wdata[`LRT_GAUGE_HI:`LRT_GAUGE_LO], 2))
    else $error("gauge decode wrong");

  a_slicer_decode: assert property (@(posedge core_clk) disable iff (!reset_n)
    ##1 tuning.slicer_level == (($past(tune_reg[`LRT_SLICE_HI:`LRT_SLICE_LO]) == FOLD_CODE) ?
      FOLD_TARGET : $past(tune_reg[`LRT_SLICE_HI:`LRT_SLICE_LO])))
    else $error("slicer decode wrong");

  a_eq_decode: assert property (@(posedge core_clk) disable iff (!reset_n)
    ##1 tuning.eq_gain == (($past(tune_reg[`LRT_EQ_HI:`LRT_EQ_LO]) == FOLD_CODE) ?
      FOLD_TARGET : $past(tune_reg[`LRT_EQ_HI:`LRT_EQ_LO])))
    else $error("equalizer decode wrong");

  a_handover_pass: assert property (@(posedge core_clk) disable iff (!reset_n)
    ##1 tuning.tx_enable_pin_handover == $past(tune_reg[`LRT_TXON_BIT])
      && tuning.termination_pin_handover == $past(tune_reg[`LRT_TERM_BIT]))
    else $error("handover bits not passed through");
endmodule // lrt_tuning_reg
`default_nettype wire

// ==== bench/lrt_tuning_reg_tb.sv ====
// Self-checking bench for the receive tuning register.
`default_nettype none
module lrt_tuning_reg_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic host_wr = 1'b0;
  logic [6:0] host_addr = 7'h42;
  logic [7:0] host_wdata = 8'h00;
  logic [7:0] host_rdata;
  lrt_pkg::lrt_tuning_t tuning;
  int error_cnt = 0;
  int comparisons = 0;
  lrt_tuning_reg dut (.core_clk(core_clk), .reset_n(reset_n), .host_wr(host_wr), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .tuning(tuning));
  always #4 core_clk = ~core_clk;
  function automatic logic [7:0] dec(input logic [7:0] d);
    return {d[7:6], (d[3:2] == 2'h3) ? 2'h0 : d[3:2], (d[1:0] == 2'h3) ? 2'h0 : d[1:0], d[5], d[4]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits two cycles so both the readback and the decoded outputs have settled.
  task automatic put(input logic [6:0] a, input logic [7:0] d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge core_clk);
    host_wr = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic t_after_reset();
    repeat (2) @(negedge core_clk);
    chk(host_rdata, 8'h00);
    chk(tuning, 8'h00);
  endtask
  task automatic t_codes();
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {4{i[1:0]}};
      put(7'h42, d);
      chk(host_rdata, d);
      chk(tuning, dec(d));
    end
  endtask
  task automatic t_unmapped();
    put(7'h43, 8'h00);
    chk(host_rdata, 8'h00);
    chk(tuning, dec(8'hff));
    host_addr = 7'h42;
    repeat (2) @(negedge core_clk);
    chk(host_rdata, 8'hff);
  endtask
  // Back-to-back writes whose fields all differ, so a swapped field cannot hide.
  task automatic t_mixed();
    host_addr = 7'h42;
    host_wdata = 8'h1b;
    host_wr = 1'b1;
    @(negedge core_clk);
    chk(host_rdata, 8'h1b);
    host_wdata = 8'he4;
    @(negedge core_clk);
    host_wr = 1'b0;
    chk(host_rdata, 8'he4);
    chk(tuning, dec(8'h1b));
    @(negedge core_clk);
    chk(tuning, dec(8'he4));
    chk(host_rdata, 8'he4);
  endtask
  // Reset in mid-run over a non-zero byte, so a reset path that misses one of its set bits 7, 6, 5 or 2 shows up.
  task automatic t_reset();
    reset_n = 1'b0;
    @(negedge core_clk);
    chk(host_rdata, 8'h00);
    chk(tuning, 8'h00);
    reset_n = 1'b1;
    t_after_reset();
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    t_after_reset();
    t_codes();
    t_unmapped();
    t_mixed();
    t_reset();
    test_done();
  end
  // A hang is cut short well beyond the few dozen cycles the run needs.
  initial begin
    #2000;
    error_cnt++;
    test_done();
  end
endmodule // lrt_tuning_reg_tb
`default_nettype wire
